// *** core/tdr_pkg.sv ***
// Shared constants and types for the torus router link ends
package tdr_pkg;
  // ==========================================================
  // Channel geometry
  localparam int DATA_W = 16;
  localparam int NUM_VC = 4;
  localparam int VC_W = 2;
  localparam int VC_DEPTH = 8;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_RESET = 4'h0;
  // ==========================================================
  // Virtual channel numbers
  localparam logic [VC_W-1:0] VC_REQ0 = 2'h0;
  localparam logic [VC_W-1:0] VC_REQ1 = 2'h1;
  localparam logic [VC_W-1:0] VC_RSP0 = 2'h2;
  localparam logic [VC_W-1:0] VC_RSP1 = 2'h3;
  localparam int VC_CLASS_BIT = 1;
  // ==========================================================
  // Header routing fields, one per dimension
  localparam int NUM_DIM = 3;
  localparam int FIELD_W = 5;
  localparam int HOP_W = 3;
  localparam int HOP_LSB = 0;
  localparam int NEG_BIT = 3;
  localparam int DL_BIT = 4;
  localparam int X_LSB = 0;
  localparam int Y_LSB = 5;
  localparam int Z_LSB = 10;
  // ==========================================================
  // Output ports: {dimension, negative}
  typedef enum logic [2:0] {
    PORT_XP = 3'h0,
    PORT_XN = 3'h1,
    PORT_YP = 3'h2,
    PORT_YN = 3'h3,
    PORT_ZP = 3'h4,
    PORT_ZN = 3'h5,
    PORT_LOCAL = 3'h6
  } tdr_port_t;
  // ==========================================================
  // Packet position
  typedef enum logic {
    ST_HEAD = 1'b0,
    ST_BODY = 1'b1
  } tdr_pkt_st_t;
endpackage

// *** core/tdr_link_if.sv ***
// One torus link: two one-way channels with control and acknowledge
`timescale 1ns/1ns
interface tdr_link_if;
  import tdr_pkg::*;
  // Channel A: peer to router
  logic a_valid;
  logic [VC_W-1:0] a_vc;
  logic a_last;
  logic [DATA_W-1:0] a_data;
  logic [NUM_VC-1:0] a_ack;
  // Channel B: router to peer
  logic b_valid;
  logic [VC_W-1:0] b_vc;
  logic b_last;
  logic [DATA_W-1:0] b_data;
  logic [NUM_VC-1:0] b_ack;

  modport router (
    input a_valid,
    input a_vc,
    input a_last,
    input a_data,
    output a_ack,
    output b_valid,
    output b_vc,
    output b_last,
    output b_data,
    input b_ack
  );
  modport peer (
    output a_valid,
    output a_vc,
    output a_last,
    output a_data,
    input a_ack,
    input b_valid,
    input b_vc,
    input b_last,
    input b_data,
    output b_ack
  );
endinterface

// *** core/tdr_router_end.sv ***
// Router end of a torus link: VC buffers, credit sender, dimension routing
`timescale 1ns/1ns

// ==========================================================
// Channel receiver: four VC buffers, packet-locked drain
module tdr_chan_rx (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Channel
  input wire logic ch_valid,
  input wire logic [tdr_pkg::VC_W-1:0] ch_vc,
  input wire logic ch_last,
  input wire logic [tdr_pkg::DATA_W-1:0] ch_data,
  output logic [tdr_pkg::NUM_VC-1:0] ch_ack,
  // User stream
  output logic o_valid,
  input wire logic o_ready,
  output logic [tdr_pkg::VC_W-1:0] o_vc,
  output logic o_last,
  output logic [tdr_pkg::DATA_W-1:0] o_data,
  output logic o_err
);
  import tdr_pkg::*;
  localparam int FW = DATA_W + 1;
  logic [NUM_VC-1:0] f_in_valid, f_in_ready, f_out_valid, f_out_ready;
  logic [FW-1:0] f_out_data [NUM_VC];
  logic [VC_W-1:0] sel, sel_r, sel_nxt;
  logic lock_r, lock_nxt, pop, found;
  logic [NUM_VC-1:0] ack_r, ack_nxt;
  logic err_r, err_nxt;

  for (genvar v = 0; v < NUM_VC; v++) begin : g_vc
    assign f_in_valid[v] = ch_valid && ch_vc == VC_W'(v);
    assign f_out_ready[v] = pop && sel == VC_W'(v);
    tdr_fifo #(.W(FW), .D(VC_DEPTH)) u_buf (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .in_valid(f_in_valid[v]),
      .in_ready(f_in_ready[v]),
      .in_data({ch_last, ch_data}),
      .out_valid(f_out_valid[v]),
      .out_ready(f_out_ready[v]),
      .out_data(f_out_data[v])
    );
  end

  assign o_valid = f_out_valid[sel];
  assign o_vc = sel;
  assign o_last = f_out_data[sel][DATA_W];
  assign o_data = f_out_data[sel][DATA_W-1:0];
  assign ch_ack = ack_r;
  assign o_err = err_r;

  always_comb begin
    sel = sel_r;
    found = lock_r;
    for (int v = 0; v < NUM_VC; v++) begin
      if (!found && f_out_valid[v]) begin
        found = 1'b1;
        sel = VC_W'(v);
      end
    end
    pop = o_valid && o_ready;
    sel_nxt = sel;
    lock_nxt = lock_r;
    if (pop) begin
      lock_nxt = !o_last;
    end
    ack_nxt = f_out_ready;
    err_nxt = ch_valid && !f_in_ready[ch_vc];
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sel_r <= '0;
      lock_r <= 1'b0;
      ack_r <= '0;
      err_r <= 1'b0;
    end else begin
      sel_r <= sel_nxt;
      lock_r <= lock_nxt;
      ack_r <= ack_nxt;
      err_r <= err_nxt;
    end
  end
endmodule

// ==========================================================
// Router end of one link
module tdr_router_end (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Link
  tdr_link_if.router lnk,
  // Forwarded traffic toward a switch port
  output logic fwd_valid,
  input wire logic fwd_ready,
  output tdr_pkg::tdr_port_t fwd_port,
  output logic [tdr_pkg::VC_W-1:0] fwd_vc,
  output logic fwd_last,
  output logic [tdr_pkg::DATA_W-1:0] fwd_data,
  // Traffic sent back over the return channel
  input wire logic rsp_valid,
  output logic rsp_ready,
  input wire logic [tdr_pkg::VC_W-1:0] rsp_vc,
  input wire logic rsp_last,
  input wire logic [tdr_pkg::DATA_W-1:0] rsp_data,
  // Status
  output logic rx_err
);
  import tdr_pkg::*;
  logic r_valid, r_ready, r_last, take, hit;
  logic [VC_W-1:0] r_vc;
  logic [DATA_W-1:0] r_data, hdr;
  logic [1:0] dim;
  tdr_pkt_st_t st_r, st_nxt;
  tdr_port_t port_r, port_nxt;
  logic [VC_W-1:0] vc_r, vc_nxt;
  logic vld_r, vld_nxt, last_r, last_nxt;
  logic [DATA_W-1:0] dat_r, dat_nxt;

  // ==========================================================
  // Channel ends
  tdr_chan_rx u_rx (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ch_valid(lnk.a_valid),
    .ch_vc(lnk.a_vc),
    .ch_last(lnk.a_last),
    .ch_data(lnk.a_data),
    .ch_ack(lnk.a_ack),
    .o_valid(r_valid),
    .o_ready(r_ready),
    .o_vc(r_vc),
    .o_last(r_last),
    .o_data(r_data),
    .o_err(rx_err)
  );

  tdr_chan_tx u_tx (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .s_valid(rsp_valid),
    .s_ready(rsp_ready),
    .s_vc(rsp_vc),
    .s_last(rsp_last),
    .s_data(rsp_data),
    .ch_valid(lnk.b_valid),
    .ch_vc(lnk.b_vc),
    .ch_last(lnk.b_last),
    .ch_data(lnk.b_data),
    .ch_ack(lnk.b_ack)
  );

  // ==========================================================
  // Dimension order routing
  assign r_ready = !vld_r || fwd_ready;
  assign fwd_valid = vld_r;
  assign fwd_port = port_r;
  assign fwd_vc = vc_r;
  assign fwd_last = last_r;
  assign fwd_data = dat_r;

  always_comb begin
    take = r_valid && r_ready;
    hit = 1'b0;
    dim = 2'h0;
    for (int d = 0; d < NUM_DIM; d++) begin
      if (!hit && r_data[d*FIELD_W+HOP_LSB +: HOP_W] != '0) begin
        hit = 1'b1;
        dim = 2'(d);
      end
    end
    hdr = r_data;
    hdr[dim*FIELD_W+HOP_LSB +: HOP_W] = r_data[dim*FIELD_W+HOP_LSB +: HOP_W] - 1'b1;
    st_nxt = st_r;
    port_nxt = port_r;
    vc_nxt = vc_r;
    vld_nxt = vld_r && !fwd_ready;
    last_nxt = last_r;
    dat_nxt = dat_r;
    if (take) begin
      vld_nxt = 1'b1;
      last_nxt = r_last;
      dat_nxt = r_data;
      st_nxt = r_last ? ST_HEAD : ST_BODY;
      if (st_r == ST_HEAD) begin
        if (hit) begin
          // Ring wrap needs no special case: hop count picks the dimension, NEG_BIT the direction, DL_BIT the low VC bit
          port_nxt = tdr_port_t'({dim, r_data[dim*FIELD_W+NEG_BIT]});
          vc_nxt = {r_vc[VC_CLASS_BIT], r_data[dim*FIELD_W+DL_BIT]};
          dat_nxt = hdr;
        end else begin
          port_nxt = PORT_LOCAL;
          vc_nxt = r_vc;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_r <= ST_HEAD;
      port_r <= PORT_LOCAL;
      vc_r <= VC_REQ0;
      vld_r <= 1'b0;
      last_r <= 1'b0;
      dat_r <= '0;
    end else begin
      st_r <= st_nxt;
      port_r <= port_nxt;
      vc_r <= vc_nxt;
      vld_r <= vld_nxt;
      last_r <= last_nxt;
      dat_r <= dat_nxt;
    end
  end
endmodule

// *** core/tdr_peer_end.sv ***
// Neighbour end of a torus link, with the shared FIFO and channel sender
`timescale 1ns/1ns

// ==========================================================
// Parameterised FIFO
module tdr_fifo #(
  parameter int W = 17,
  parameter int D = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);
  logic [W-1:0] mem_r [D];
  logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic push, pop;

  assign in_ready = cnt_r != CW'(D);
  assign out_valid = cnt_r != '0;
  assign out_data = mem_r[rd_r];

  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wr_nxt = wr_r;
    rd_nxt = rd_r;
    if (push) begin
      wr_nxt = (wr_r == AW'(D - 1)) ? '0 : wr_r + 1'b1;
    end
    if (pop) begin
      rd_nxt = (rd_r == AW'(D - 1)) ? '0 : rd_r + 1'b1;
    end
    cnt_nxt = cnt_r + CW'(push) - CW'(pop);
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end
endmodule

// ==========================================================
// Channel sender with per-VC occupancy counts
module tdr_chan_tx (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // User stream
  input wire logic s_valid,
  output logic s_ready,
  input wire logic [tdr_pkg::VC_W-1:0] s_vc,
  input wire logic s_last,
  input wire logic [tdr_pkg::DATA_W-1:0] s_data,
  // Channel
  output logic ch_valid,
  output logic [tdr_pkg::VC_W-1:0] ch_vc,
  output logic ch_last,
  output logic [tdr_pkg::DATA_W-1:0] ch_data,
  input wire logic [tdr_pkg::NUM_VC-1:0] ch_ack
);
  import tdr_pkg::*;
  logic [CNT_W-1:0] cnt_r [NUM_VC];
  logic [CNT_W-1:0] cnt_nxt [NUM_VC];
  logic send;
  logic vld_r, vld_nxt, last_r, last_nxt;
  logic [VC_W-1:0] vc_r, vc_nxt;
  logic [DATA_W-1:0] dat_r, dat_nxt;

  assign s_ready = cnt_r[s_vc] < CNT_W'(VC_DEPTH);
  assign ch_valid = vld_r;
  assign ch_vc = vc_r;
  assign ch_last = last_r;
  assign ch_data = dat_r;

  always_comb begin
    send = s_valid && s_ready;
    for (int v = 0; v < NUM_VC; v++) begin
      cnt_nxt[v] = cnt_r[v] + CNT_W'(send && s_vc == VC_W'(v)) - CNT_W'(ch_ack[v]);
    end
    vld_nxt = send;
    vc_nxt = send ? s_vc : vc_r;
    last_nxt = send ? s_last : last_r;
    dat_nxt = send ? s_data : dat_r;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      for (int v = 0; v < NUM_VC; v++) begin
        cnt_r[v] <= CNT_RESET;
      end
      vld_r <= 1'b0;
      vc_r <= '0;
      last_r <= 1'b0;
      dat_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
      vld_r <= vld_nxt;
      vc_r <= vc_nxt;
      last_r <= last_nxt;
      dat_r <= dat_nxt;
    end
  end
endmodule

// ==========================================================
// Neighbour end of one link
module tdr_peer_end (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Link
  tdr_link_if.peer lnk,
  // Outgoing packets
  input wire logic snd_valid,
  output logic snd_ready,
  input wire logic [tdr_pkg::VC_W-1:0] snd_vc,
  input wire logic snd_last,
  input wire logic [tdr_pkg::DATA_W-1:0] snd_data,
  // Incoming packets
  output logic rcv_valid,
  input wire logic rcv_ready,
  output logic [tdr_pkg::VC_W-1:0] rcv_vc,
  output logic rcv_last,
  output logic [tdr_pkg::DATA_W-1:0] rcv_data,
  // Status
  output logic rcv_err
);
  import tdr_pkg::*;

  // ==========================================================
  // Sender on channel A
  tdr_chan_tx u_tx (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .s_valid(snd_valid),
    .s_ready(snd_ready),
    .s_vc(snd_vc),
    .s_last(snd_last),
    .s_data(snd_data),
    .ch_valid(lnk.a_valid),
    .ch_vc(lnk.a_vc),
    .ch_last(lnk.a_last),
    .ch_data(lnk.a_data),
    .ch_ack(lnk.a_ack)
  );

  // ==========================================================
  // Receiver on channel B
  tdr_chan_rx u_rx (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ch_valid(lnk.b_valid),
    .ch_vc(lnk.b_vc),
    .ch_last(lnk.b_last),
    .ch_data(lnk.b_data),
    .ch_ack(lnk.b_ack),
    .o_valid(rcv_valid),
    .o_ready(rcv_ready),
    .o_vc(rcv_vc),
    .o_last(rcv_last),
    .o_data(rcv_data),
    .o_err(rcv_err)
  );
endmodule

// *** tb/tdr_link_monitor.sv ***
// Checker for credit and acknowledge relations on both link channels
`timescale 1ns/1ns
module tdr_link_monitor (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Channel A
  input wire logic a_valid,
  input wire logic [tdr_pkg::VC_W-1:0] a_vc,
  input wire logic [tdr_pkg::NUM_VC-1:0] a_ack,
  // Channel B
  input wire logic b_valid,
  input wire logic [tdr_pkg::VC_W-1:0] b_vc,
  input wire logic [tdr_pkg::NUM_VC-1:0] b_ack
);
  import tdr_pkg::*;
  // ==========================================================
  // Outstanding phits per VC
  logic [CNT_W-1:0] a_occ_r [NUM_VC];
  logic [CNT_W-1:0] a_occ_nxt [NUM_VC];
  logic [CNT_W-1:0] b_occ_r [NUM_VC];
  logic [CNT_W-1:0] b_occ_nxt [NUM_VC];
  logic [NUM_VC-1:0] a_busy, b_busy, a_over;
  always_comb begin
    for (int v = 0; v < NUM_VC; v++) begin
      a_occ_nxt[v] = a_occ_r[v] + CNT_W'(a_valid && a_vc == v) - CNT_W'(a_ack[v]);
      b_occ_nxt[v] = b_occ_r[v] + CNT_W'(b_valid && b_vc == v) - CNT_W'(b_ack[v]);
      a_busy[v] = a_occ_r[v] != CNT_RESET;
      b_busy[v] = b_occ_r[v] != CNT_RESET;
      a_over[v] = a_occ_r[v] > CNT_W'(VC_DEPTH);
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      for (int v = 0; v < NUM_VC; v++) begin
        a_occ_r[v] <= CNT_RESET;
        b_occ_r[v] <= CNT_RESET;
      end
    end else begin
      a_occ_r <= a_occ_nxt;
      b_occ_r <= b_occ_nxt;
    end
  end
  // ==========================================================
  // Assertions
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_a_first;
    a_valid && !a_busy[a_vc];
  endsequence
  sequence s_b_first;
    b_valid && !b_busy[b_vc];
  endsequence
  property p_a_ack_one;
    $onehot0(a_ack);
  endproperty
  property p_a_credit;
    (a_ack & ~a_busy) == '0;
  endproperty
  property p_b_credit;
    (b_ack & ~b_busy) == '0;
  endproperty
  property p_a_depth;
    a_over == '0;
  endproperty
  property p_a_ack_min;
    s_a_first |=> !a_ack[$past(a_vc)];
  endproperty
  property p_b_ack_min;
    s_b_first |=> !b_ack[$past(b_vc)];
  endproperty
  property p_rst_idle;
    $rose(rst_n) |-> !a_valid && !b_valid && a_ack == '0 && b_ack == '0;
  endproperty
  property p_b_depth;
    b_valid |-> b_occ_r[b_vc] < CNT_W'(VC_DEPTH);
  endproperty
  a_a_ack_one: assert property (p_a_ack_one) else $error("two acks at once");
  a_a_credit: assert property (p_a_credit) else $error("ack without phit on A");
  a_b_credit: assert property (p_b_credit) else $error("ack without phit on B");
  a_a_depth: assert property (p_a_depth) else $error("VC overfilled on A");
  a_a_ack_min: assert property (p_a_ack_min) else $error("early ack on A");
  a_b_ack_min: assert property (p_b_ack_min) else $error("early ack on B");
  a_rst_idle: assert property (p_rst_idle) else $error("link busy after reset");
  a_b_depth: assert property (p_b_depth) else $error("send without credit on B");
endmodule

// *** tb/torus_dimension_order_router_tb_top.sv ***
// Bench: router end and peer end joined over one link, checked against a model
`timescale 1ns/1ns
module torus_dimension_order_router_tb_top;
  import tdr_pkg::*;
  // ==========================================================
  // Signals and model state
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic snd_valid = 1'b0, snd_ready, snd_last = 1'b0, rcv_valid, rcv_ready = 1'b0;
  logic rcv_last, rcv_err, fwd_valid, fwd_ready = 1'b0, fwd_last, rx_err;
  logic rsp_valid = 1'b0, rsp_ready, rsp_last = 1'b0;
  logic [VC_W-1:0] snd_vc = 2'h0, rcv_vc, fwd_vc, rsp_vc = 2'h0;
  logic [DATA_W-1:0] snd_data = 16'h0000, rcv_data, fwd_data, rsp_data = 16'h0000;
  tdr_port_t fwd_port;
  int failures = 0;
  int num_checks = 0;
  int seed = 32'h9ba38973;
  int n;
  bit stall = 1'b0;
  bit in_body = 1'b0;
  logic [4:0] hdr_r = 5'h00;
  logic [21:0] fq[$];
  logic [18:0] rq[NUM_VC][$];
  tdr_link_if lnk ();
  tdr_router_end i_tdr_router_end (.core_clk(core_clk), .rst_n(rst_n), .lnk(lnk),
    .fwd_valid(fwd_valid), .fwd_ready(fwd_ready), .fwd_port(fwd_port), .fwd_vc(fwd_vc),
    .fwd_last(fwd_last), .fwd_data(fwd_data), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
    .rsp_vc(rsp_vc), .rsp_last(rsp_last), .rsp_data(rsp_data), .rx_err(rx_err));
  tdr_peer_end i_tdr_peer_end (.core_clk(core_clk), .rst_n(rst_n), .lnk(lnk),
    .snd_valid(snd_valid), .snd_ready(snd_ready), .snd_vc(snd_vc), .snd_last(snd_last),
    .snd_data(snd_data), .rcv_valid(rcv_valid), .rcv_ready(rcv_ready), .rcv_vc(rcv_vc),
    .rcv_last(rcv_last), .rcv_data(rcv_data), .rcv_err(rcv_err));
  tdr_link_monitor i_tdr_link_monitor (.core_clk(core_clk), .rst_n(rst_n),
    .a_valid(lnk.a_valid), .a_vc(lnk.a_vc), .a_ack(lnk.a_ack), .b_valid(lnk.b_valid),
    .b_vc(lnk.b_vc), .b_ack(lnk.b_ack));
  initial begin
    forever #10 core_clk = ~core_clk;
  end
  // ==========================================================
  // Checks and model
  task automatic chk(input logic [21:0] got, input logic [21:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  function automatic int pend();
    return fq.size() + rq[0].size() + rq[1].size() + rq[2].size() + rq[3].size();
  endfunction
  task automatic exp_fwd(input logic [1:0] v, input logic l, input logic [15:0] d);
    logic [21:0] r;
    r = {3'h6, v, l, d};
    for (int k = NUM_DIM - 1; k >= 0; k--) begin
      if (d[FIELD_W*k+HOP_LSB +: HOP_W] != 3'h0) begin
        r = {k[1:0], d[FIELD_W*k+NEG_BIT], v[VC_CLASS_BIT], d[FIELD_W*k+DL_BIT], l,
          d - (16'h1 << (FIELD_W*k))};
      end
    end
    if (in_body) r = {hdr_r, l, d};
    hdr_r = r[21:17];
    in_body = !l;
    fq.push_back(r);
  endtask
  task automatic snd(input logic [1:0] v, input logic l, input logic [15:0] d);
    snd_valid = 1'b1;
    snd_vc = v;
    snd_last = l;
    snd_data = d;
    @(negedge core_clk);
    while (snd_ready !== 1'b1) @(negedge core_clk);
    @(posedge core_clk);
    #2;
    exp_fwd(v, l, d);
  endtask
  task automatic rsp(input logic [1:0] v, input logic l, input logic [15:0] d);
    rsp_valid = 1'b1;
    rsp_vc = v;
    rsp_last = l;
    rsp_data = d;
    @(negedge core_clk);
    while (rsp_ready !== 1'b1) @(negedge core_clk);
    @(posedge core_clk);
    #2;
    rq[v].push_back({v, l, d});
  endtask
  task automatic drain();
    for (int i = 0; i < 3000 && pend() != 0; i++) @(posedge core_clk);
    #2;
    chk(22'(pend()), 22'h0);
  endtask
  always @(posedge core_clk) begin
    if (rst_n === 1'b1) begin
      chk({20'h0, rx_err, rcv_err}, 22'h0);
      if (fwd_valid === 1'b1 && fwd_ready === 1'b1) begin
        chk({fwd_port, fwd_vc, fwd_last, fwd_data}, fq.pop_front());
      end
      if (rcv_valid === 1'b1 && rcv_ready === 1'b1) begin
        chk({3'h0, rcv_vc, rcv_last, rcv_data}, {3'h0, rq[rcv_vc].pop_front()});
      end
    end
  end
  always @(posedge core_clk) begin
    #2;
    if (stall) begin
      fwd_ready = 1'($random(seed));
      rcv_ready = 1'($random(seed));
    end
  end
  initial begin
    #1000000;
    failures++;
    final_report();
  end
  // ==========================================================
  // Scenarios
  initial begin
    repeat (12) @(posedge core_clk);
    #2;
    rst_n = 1'b1;
    @(posedge core_clk);
    #2;
    stall = 1'b1;
    for (int v = 0; v < NUM_VC; v++) begin
      snd(2'(v), 1'b1, 16'h0000);
      snd(2'(v), 1'b1, 16'h8000);
      snd(2'(v), 1'b1, 16'h0011);
      snd(2'(v), 1'b1, 16'h00E0);
      snd(2'(v), 1'b1, 16'h3C00);
      for (int i = 0; i < 15; i++) snd(2'(v), 1'(i % 3 == 2), 16'($random(seed)));
      snd_valid = 1'b0;
      drain();
    end
    @(posedge core_clk);
    stall = 1'b0;
    #2;
    fwd_ready = 1'b0;
    rcv_ready = 1'b0;
    snd_valid = 1'b1;
    snd_vc = VC_REQ1;
    snd_last = 1'b0;
    snd_data = 16'h0021;
    n = 0;
    @(negedge core_clk);
    while (snd_ready === 1'b1 && n < 12) begin
      @(posedge core_clk);
      #2;
      exp_fwd(snd_vc, snd_last, snd_data);
      snd_data = 16'($random(seed));
      n++;
      @(negedge core_clk);
    end
    @(posedge core_clk);
    #2;
    chk(22'(n >= 8 && n <= 9), 22'h1);
    snd_valid = 1'b0;
    snd_vc = VC_RSP0;
    @(negedge core_clk);
    chk({21'h0, snd_ready}, 22'h1);
    @(posedge core_clk);
    #2;
    fwd_ready = 1'b1;
    snd(VC_REQ1, 1'b1, 16'($random(seed)));
    snd_valid = 1'b0;
    drain();
    n = 0;
    rsp_valid = 1'b1;
    rsp_vc = VC_RSP1;
    rsp_last = 1'b1;
    @(negedge core_clk);
    while (rsp_ready === 1'b1 && n < 12) begin
      @(posedge core_clk);
      #2;
      rq[VC_RSP1].push_back({rsp_vc, rsp_last, rsp_data});
      rsp_data = 16'($random(seed));
      n++;
      @(negedge core_clk);
    end
    @(posedge core_clk);
    #2;
    chk(22'(n), 22'h8);
    rsp_valid = 1'b0;
    stall = 1'b1;
    for (int v = 0; v < NUM_VC; v++) begin
      for (int i = 0; i < 10; i++) rsp(2'(v), 1'(i % 5 == 4), 16'($random(seed)));
    end
    rsp_valid = 1'b0;
    drain();
    final_report();
  end
endmodule
